// file: logic/dioms_pkg.sv
// Purpose: constants and state type for the switch-to-contact monitor
// Assumes: 10 MHz REF_CLK, Avalon-MM register slave
// Notes: register offsets are byte addresses
package dioms_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NE = 36;
    localparam int NSW = 64;
    localparam int NDO = 32;
    localparam int NDI = 32;
    localparam int CW = 24;
    localparam int AW = 9;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 10_000;
    localparam int PULSE_MS = 1500;
    localparam int PULSE_CYC = PULSE_MS * CLK_KHZ;
    // ------------------------------------------------------------
    // register map and entry fields
    // ------------------------------------------------------------
    localparam logic [AW-1:0] ENTRY_BASE = 9'h000;
    localparam logic [AW-1:0] SW_LO = 9'h100;
    localparam logic [AW-1:0] SW_HI = 9'h104;
    localparam logic [AW-1:0] SHOWN_LO = 9'h108;
    localparam logic [AW-1:0] SHOWN_HI = 9'h10C;
    localparam logic [AW-1:0] OUT_STATE = 9'h110;
    localparam logic [AW-1:0] IN_STATE = 9'h114;
    localparam int EN_BIT = 0;
    localparam int TYPE_LSB = 1;
    localparam int SW_LSB = 4;
    localparam int ON_LSB = 10;
    localparam int OFF_LSB = 15;
    localparam int DI_LSB = 20;
    localparam int CFGW = 25;
    localparam logic [CFGW-1:0] CFG_RESET = 25'h000_0000;
    // ------------------------------------------------------------
    // monitor entry types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        input_display_type = 3'h0,
        single_type = 3'h1,
        dual_type = 3'h2,
        dual_pulse_type = 3'h3,
        input_plus_single_type = 3'h4,
        input_plus_dual_type = 3'h5,
        input_plus_pulse_type = 3'h6
    } dioms_kind_t;
    typedef struct packed {
        logic [NE-1:0][CFGW-1:0] cfg;
        logic [NSW-1:0] sw;
        logic [NDI-1:0] in_s1;
        logic [NDI-1:0] in_s2;
        logic [NE-1:0] last_sw;
        logic [NE-1:0] pulse_act;
        logic [NE-1:0] pulse_dir;
        logic [NE-1:0][CW-1:0] pulse_cnt;
        logic [NDO-1:0] do_out;
        logic [NE-1:0] shown;
        logic ack;
        logic [31:0] rdata;
    } dioms_state_t;
endpackage : dioms_pkg

// file: logic/dioms_top.sv
// Purpose: maps internal switches onto contact outputs, shows inputs
// Assumes: one clock, software writes switch and entry registers
// Notes: fail outputs override the monitor, which overrides others
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dioms_top #(
    parameter int PULSE_CYCLES = dioms_pkg::PULSE_CYC
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // avalon-mm slave
    input wire logic [dioms_pkg::AW-1:0] AV_ADDRESS,
    input wire logic AV_READ,
    input wire logic AV_WRITE,
    input wire logic [3:0] AV_BYTEENABLE,
    input wire logic [31:0] AV_WRITEDATA,
    output logic [31:0] AV_READDATA,
    output logic AV_WAITREQUEST,
    // contacts
    input wire logic [dioms_pkg::NDI-1:0] CONTACT_IN,
    output logic [dioms_pkg::NDO-1:0] CONTACT_OUT,
    output logic [dioms_pkg::NE-1:0] INPUT_SHOWN,
    // other output sources
    input wire logic [dioms_pkg::NDO-1:0] FAIL_EN,
    input wire logic [dioms_pkg::NDO-1:0] FAIL_VAL,
    input wire logic [dioms_pkg::NDO-1:0] OTHER_VAL
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic is_entry(input logic [dioms_pkg::AW-1:0] a);
        return (a[8:2] < 7'(dioms_pkg::NE)) && (a[8] == 1'b0);
    endfunction : is_entry

    function automatic logic shows_input(input logic [2:0] k);
        return (k == dioms_pkg::input_display_type)
            || (k == dioms_pkg::input_plus_single_type)
            || (k == dioms_pkg::input_plus_dual_type)
            || (k == dioms_pkg::input_plus_pulse_type);
    endfunction : shows_input

    localparam logic [dioms_pkg::CW-1:0] PC_LAST = dioms_pkg::CW'(PULSE_CYCLES - 1);

    dioms_pkg::dioms_state_t r_reg;
    dioms_pkg::dioms_state_t r_next;
    logic [dioms_pkg::NDO-1:0] claim;
    logic [dioms_pkg::NDO-1:0] mval;
    logic [31:0] rd_val;
    logic [dioms_pkg::CFGW-1:0] c;
    logic [2:0] kind;
    logic sw_now;
    logic [4:0] on_n;
    logic [4:0] off_n;
    logic [5:0] idx;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        r_next = r_reg;
        claim = '0;
        mval = '0;
        c = '0;
        kind = 3'h0;
        sw_now = 1'b0;
        on_n = 5'h0;
        off_n = 5'h0;
        idx = AV_ADDRESS[7:2];
        r_next.in_s1 = CONTACT_IN;
        r_next.in_s2 = r_reg.in_s1;
        // bus: one wait cycle, then answer
        r_next.ack = (AV_READ | AV_WRITE) & ~r_reg.ack;
        rd_val = 32'h0000_0000;
        if (is_entry(AV_ADDRESS))
        begin
            rd_val = 32'(r_reg.cfg[idx]);
        end
        else
        begin
            case (AV_ADDRESS)
                dioms_pkg::SW_LO: rd_val = r_reg.sw[31:0];
                dioms_pkg::SW_HI: rd_val = r_reg.sw[63:32];
                dioms_pkg::SHOWN_LO: rd_val = r_reg.shown[31:0];
                dioms_pkg::SHOWN_HI: rd_val = 32'(r_reg.shown[35:32]);
                dioms_pkg::OUT_STATE: rd_val = r_reg.do_out;
                dioms_pkg::IN_STATE: rd_val = r_reg.in_s2;
                default: rd_val = 32'h0000_0000;
            endcase
        end
        r_next.rdata = AV_READ ? rd_val : 32'h0000_0000;
        if (AV_WRITE && r_reg.ack)
        begin
            if (is_entry(AV_ADDRESS))
            begin
                r_next.cfg[idx] = dioms_pkg::CFGW'(merge(32'(r_reg.cfg[idx]),
                    AV_WRITEDATA, AV_BYTEENABLE));
            end
            else if (AV_ADDRESS == dioms_pkg::SW_LO)
            begin
                r_next.sw[31:0] = merge(r_reg.sw[31:0], AV_WRITEDATA, AV_BYTEENABLE);
            end
            else if (AV_ADDRESS == dioms_pkg::SW_HI)
            begin
                r_next.sw[63:32] = merge(r_reg.sw[63:32], AV_WRITEDATA, AV_BYTEENABLE);
            end
        end
        // per-entry behaviour
        for (int i = 0; i < dioms_pkg::NE; i++)
        begin
            c = r_reg.cfg[i];
            kind = c[dioms_pkg::TYPE_LSB +: 3];
            sw_now = r_reg.sw[c[dioms_pkg::SW_LSB +: 6]];
            on_n = c[dioms_pkg::ON_LSB +: 5];
            off_n = c[dioms_pkg::OFF_LSB +: 5];
            r_next.last_sw[i] = sw_now;
            r_next.shown[i] = c[dioms_pkg::EN_BIT] && shows_input(kind)
                && r_reg.in_s2[c[dioms_pkg::DI_LSB +: 5]];
            if (!c[dioms_pkg::EN_BIT])
            begin
                r_next.pulse_act[i] = 1'b0;
            end
            else
            begin
                case (kind)
                    dioms_pkg::single_type,
                    dioms_pkg::input_plus_single_type:
                    begin
                        claim[on_n] = 1'b1;
                        mval[on_n] = sw_now;
                        r_next.pulse_act[i] = 1'b0;
                    end
                    dioms_pkg::dual_type,
                    dioms_pkg::input_plus_dual_type:
                    begin
                        claim[on_n] = 1'b1;
                        claim[off_n] = 1'b1;
                        mval[on_n] = sw_now;
                        mval[off_n] = ~sw_now;
                        r_next.pulse_act[i] = 1'b0;
                    end
                    dioms_pkg::dual_pulse_type,
                    dioms_pkg::input_plus_pulse_type:
                    begin
                        claim[on_n] = 1'b1;
                        claim[off_n] = 1'b1;
                        mval[on_n] = r_reg.pulse_act[i] & r_reg.pulse_dir[i];
                        mval[off_n] = r_reg.pulse_act[i] & ~r_reg.pulse_dir[i];
                        if (sw_now != r_reg.last_sw[i])
                        begin
                            r_next.pulse_act[i] = 1'b1;
                            r_next.pulse_dir[i] = sw_now;
                            r_next.pulse_cnt[i] = '0;
                        end
                        else if (r_reg.pulse_act[i])
                        begin
                            if (r_reg.pulse_cnt[i] == PC_LAST)
                            begin
                                r_next.pulse_act[i] = 1'b0;
                            end
                            else
                            begin
                                r_next.pulse_cnt[i] = r_reg.pulse_cnt[i] + 1'b1;
                            end
                        end
                    end
                    default:
                    begin
                        r_next.pulse_act[i] = 1'b0;
                    end
                endcase
            end
        end
        // output priority: fail, monitor, other
        for (int k = 0; k < dioms_pkg::NDO; k++)
        begin
            r_next.do_out[k] = FAIL_EN[k] ? FAIL_VAL[k]
                : (claim[k] ? mval[k] : OTHER_VAL[k]);
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign AV_WAITREQUEST = (AV_READ | AV_WRITE) & ~r_reg.ack;
    assign AV_READDATA = r_reg.rdata;
    assign CONTACT_OUT = r_reg.do_out;
    assign INPUT_SHOWN = r_reg.shown;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [dioms_pkg::CFGW-1:0] e0;
    logic [dioms_pkg::CFGW-1:0] e1;
    logic [dioms_pkg::CFGW-1:0] e2;
    logic [dioms_pkg::CFGW-1:0] e3;
    logic [2:0] k0;
    assign e0 = r_reg.cfg[0];
    assign e1 = r_reg.cfg[1];
    assign e2 = r_reg.cfg[2];
    assign e3 = r_reg.cfg[3];
    assign k0 = e0[dioms_pkg::TYPE_LSB +: 3];

    property p_single;
        @(posedge REF_CLK) disable iff (!NRST)
        (e0[0] && k0 == dioms_pkg::single_type && !FAIL_EN[e0[14:10]])
        |=> CONTACT_OUT[$past(e0[14:10])] == $past(r_reg.sw[e0[9:4]]);
    endproperty
    a_single: assert property (p_single) else $error("single output wrong");

    property p_dual;
        @(posedge REF_CLK) disable iff (!NRST)
        (e1[0] && e1[dioms_pkg::TYPE_LSB +: 3] == dioms_pkg::dual_type && !FAIL_EN[e1[19:15]])
        |=> CONTACT_OUT[$past(e1[19:15])] == !$past(r_reg.sw[e1[9:4]]);
    endproperty
    a_dual: assert property (p_dual) else $error("dual off output wrong");

    property p_fail;
        @(posedge REF_CLK) disable iff (!NRST)
        FAIL_EN[5] |=> CONTACT_OUT[5] == $past(FAIL_VAL[5]);
    endproperty
    a_fail: assert property (p_fail) else $error("fail output lost priority");

    property p_idle;
        @(posedge REF_CLK) disable iff (!NRST)
        (!claim[0] && !FAIL_EN[0]) |=> CONTACT_OUT[0] == $past(OTHER_VAL[0]);
    endproperty
    a_idle: assert property (p_idle) else $error("unclaimed output not other");

    property p_show;
        @(posedge REF_CLK) disable iff (!NRST)
        (e2[0] && shows_input(e2[dioms_pkg::TYPE_LSB +: 3]))
        |=> INPUT_SHOWN[2] == $past(r_reg.in_s2[e2[24:20]]);
    endproperty
    a_show: assert property (p_show) else $error("input not shown");

    property p_noshow;
        @(posedge REF_CLK) disable iff (!NRST)
        !shows_input(k0) |=> !INPUT_SHOWN[0];
    endproperty
    a_noshow: assert property (p_noshow) else $error("output-only shows input");

    property p_pstart;
        @(posedge REF_CLK) disable iff (!NRST)
        (e3[0] && e3[dioms_pkg::TYPE_LSB +: 3] == dioms_pkg::dual_pulse_type
            && r_reg.sw[e3[9:4]] != r_reg.last_sw[3])
        |=> r_reg.pulse_act[3] ##1 (CONTACT_OUT[e3[14:10]] || FAIL_EN[e3[14:10]] || !r_reg.pulse_dir[3]);
    endproperty
    a_pstart: assert property (p_pstart) else $error("pulse not started");

    property p_pend;
        @(posedge REF_CLK) disable iff (!NRST)
        (r_reg.pulse_act[3] && r_reg.pulse_cnt[3] == PC_LAST
            && r_reg.sw[e3[9:4]] == r_reg.last_sw[3]) |=> !r_reg.pulse_act[3];
    endproperty
    a_pend: assert property (p_pend) else $error("pulse overran");

    property p_bus;
        @(posedge REF_CLK) disable iff (!NRST)
        ((AV_READ || AV_WRITE) && AV_WAITREQUEST) |=> !AV_WAITREQUEST;
    endproperty
    a_bus: assert property (p_bus) else $error("waitrequest held too long");

    c_pulse: cover property (@(posedge REF_CLK) disable iff (!NRST) $fell(r_reg.pulse_act[3]));
    c_dual: cover property (@(posedge REF_CLK) disable iff (!NRST)
        e1[0] && e1[dioms_pkg::TYPE_LSB +: 3] == dioms_pkg::dual_type);
    c_show: cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(INPUT_SHOWN[2]));
endmodule : dioms_top
`default_nettype wire

// file: tb/dioms_contacts.sv
// Purpose: contact terminals on the far side of the monitor
// Assumes: same clock as the block
// Notes: keeps the length of the latest high run of every output
`timescale 1ns/1ps
`default_nettype none
module dioms_contacts (
    // clock
    input wire logic clk,
    // terminals
    input wire logic [31:0] pins,
    input wire logic [31:0] contact_out,
    output logic [31:0] contact_in
);
    int run [32];
    int last [32];
    assign contact_in = pins;
    always @(posedge clk)
    begin
        for (int i = 0; i < 32; i++)
        begin
            if (contact_out[i] === 1'b1)
                run[i] <= run[i] + 1;
            else if (run[i] != 0)
            begin
                last[i] <= run[i];
                run[i] <= 0;
            end
        end
    end
endmodule : dioms_contacts
`default_nettype wire

// file: tb/tb_switch_to_contact_output_monitor.sv
// Purpose: self-checking bench for the switch-to-contact monitor
// Assumes: one wait cycle per bus access, pulse length 20 clocks
// Notes: read results are checked against a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module tb_switch_to_contact_output_monitor;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [8:0] addr = 9'h000;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic waitreq;
    logic [31:0] pins = 32'h0000_0000;
    logic [31:0] cin;
    logic [31:0] cout;
    logic [35:0] shown;
    logic [31:0] fail_en = 32'h0000_0000;
    logic [31:0] fail_val = 32'h0000_0000;
    logic [31:0] other = 32'h0000_0000;
    logic [31:0] seed = 32'h0000_0013;
    logic [31:0] expq [$];
    int failures = 0;
    int check_count = 0;
    always #50 ref_clk = ~ref_clk;
    dioms_top #(.PULSE_CYCLES(20)) u_dut (.REF_CLK(ref_clk), .NRST(nrst), .AV_ADDRESS(addr),
        .AV_READ(rd_en), .AV_WRITE(wr_en), .AV_BYTEENABLE(4'hF), .AV_WRITEDATA(wdata),
        .AV_READDATA(rdata), .AV_WAITREQUEST(waitreq), .CONTACT_IN(cin), .CONTACT_OUT(cout),
        .INPUT_SHOWN(shown), .FAIL_EN(fail_en), .FAIL_VAL(fail_val), .OTHER_VAL(other));
    dioms_contacts u_far (.clk(ref_clk), .pins(pins), .contact_out(cout), .contact_in(cin));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [31:0] cfg(input int en, input int ty, input int sw, input int on,
        input int off, input int di);
        return 32'(en) | 32'(ty) << 1 | 32'(sw) << 4 | 32'(on) << 10 | 32'(off) << 15 | 32'(di) << 20;
    endfunction : cfg
    // monitor claims bits 5-7, 10-11, 13-17 and 22; pulse bits stay low here
    function automatic logic [31:0] exp_out(input logic s3, input logic s4);
        logic [31:0] mask;
        logic [31:0] mon;
        mask = 32'h0043_ECE0;
        mon = {9'h0, s3, 6'h0, !s4, s4, s3, 5'h0, !s4, s4, s3, 5'h0};
        return (fail_en & fail_val) | (~fail_en & mask & mon) | (~fail_en & ~mask & other);
    endfunction : exp_out
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic [8:0] a, input logic [31:0] d, input logic w);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= !w;
        @(posedge ref_clk);
        while (waitreq !== 1'b0)
        begin
            @(posedge ref_clk);
            n++;
        end
        check(32'(n), 32'h0000_0001);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(a, 32'h0000_0000, 1'b0);
    endtask : rd
    task automatic tally_and_finish();
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge ref_clk)
        if (rd_en && waitreq === 1'b0)
            check(rdata, expq.pop_front());
    // the whole run is well under 1 ms; this cuts a hung handshake short
    initial
    begin
        #(3_000_000);
        failures++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] t [10];
        logic [31:0] sh;
        t = '{cfg(1, 1, 3, 5, 0, 0), cfg(1, 2, 4, 6, 7, 0), cfg(1, 0, 0, 12, 0, 9), cfg(1, 3, 5, 10, 11, 0),
            cfg(1, 4, 3, 13, 0, 1), cfg(1, 5, 4, 14, 15, 2), cfg(1, 6, 6, 16, 17, 3), cfg(1, 7, 3, 20, 0, 0),
            cfg(0, 1, 3, 21, 0, 0), cfg(1, 1, 3, 22, 0, 4)};
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd(dioms_pkg::OUT_STATE, 32'h0000_0000);
        bus(9'h1F0, 32'hFFFF_FFFF, 1'b1);
        rd(9'h1F0, 32'h0000_0000);
        for (int i = 0; i < 10; i++)
            bus(9'(4 * i), t[i], 1'b1);
        bus(9'h08C, 32'hFFAB_CDEE, 1'b1);
        rd(9'h08C, 32'h01AB_CDEE);
        rd(9'h004, t[1]);
        bus(dioms_pkg::SW_HI, 32'h8000_0001, 1'b1);
        rd(dioms_pkg::SW_HI, 32'h8000_0001);
        for (int k = 0; k < 8; k++)
        begin
            fail_en <= k[2] ? 32'h0000_00A0 : 32'h0000_0000;
            fail_val <= rnd();
            other <= rnd();
            pins <= rnd();
            bus(dioms_pkg::SW_LO, {27'h0, k[1], k[0], 3'h0}, 1'b1);
            repeat (4) @(posedge ref_clk);
            sh = {25'h0, pins[3], pins[2], pins[1], 1'b0, pins[9], 2'b00};
            check(cout, exp_out(k[0], k[1]));
            check(shown[31:0], sh);
            rd(dioms_pkg::OUT_STATE, exp_out(k[0], k[1]));
            rd(dioms_pkg::SHOWN_LO, sh);
            rd(dioms_pkg::IN_STATE, pins);
        end
        fail_en <= 32'h0000_0000;
        bus(dioms_pkg::SW_LO, 32'h0000_0020, 1'b1);
        repeat (30) @(posedge ref_clk);
        check(32'(u_far.last[10]), 32'h0000_0014);
        check(32'(u_far.last[11]), 32'h0000_0000);
        bus(dioms_pkg::SW_LO, 32'h0000_0000, 1'b1);
        repeat (30) @(posedge ref_clk);
        check(32'(u_far.last[11]), 32'h0000_0014);
        check(32'(shown[35:32]), 32'h0000_0000);
        rd(dioms_pkg::SHOWN_HI, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : tb_switch_to_contact_output_monitor
`default_nettype wire
